// file: src/ugev_params.svh
`ifndef UGEV_PARAMS_SVH
`define UGEV_PARAMS_SVH

// ************************************************************
// register indices (byte address = index * 4)
// ************************************************************
`define UGEV_FLAGS_IDX 8'hBD
`define UGEV_ENABLES_IDX 8'hBE
`define UGEV_ADDR_IDX 8'hC6
`define UGEV_DECODE_BITS 10

// ************************************************************
// field positions and reset values
// ************************************************************
`define UGEV_BIT_WAKE 5
`define UGEV_BIT_EOR 4
`define UGEV_BIT_SOF 3
`define UGEV_BIT_SUSP 0
`define UGEV_BIT_FEN 7
`define UGEV_EVENT_MASK 8'h39
`define UGEV_FLAGS_RST 8'h00
`define UGEV_ENABLES_RST 8'h10
`define UGEV_ADDR_RST 8'h00

// ************************************************************
// timing
// ************************************************************
`define UGEV_CLK_MHZ 125
`define UGEV_FS_BIT_MHZ 12
`define UGEV_BUS_RESET_BITS 32
`define UGEV_RESET_CYCLES ((`UGEV_BUS_RESET_BITS * `UGEV_CLK_MHZ + `UGEV_FS_BIT_MHZ - 1) / `UGEV_FS_BIT_MHZ)
`define UGEV_SUSPEND_MS 3
`define UGEV_SUSPEND_CYCLES (`UGEV_SUSPEND_MS * 1000 * `UGEV_CLK_MHZ)

`endif

// file: src/ugev_pkg.sv
package ugev_pkg;

  typedef enum logic [1:0] {UGEV_LS_ACTIVE, UGEV_LS_RESET, UGEV_LS_SUSPEND} ugev_link_state_t;

  // differential line after synchronisation
  typedef struct packed {
    logic dp;
    logic dm;
  } ugev_line_t;

  // captured AHB address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] index;
  } ugev_ahb_req_t;

endpackage

// file: src/ugev_sync.sv
`timescale 1ns/1ps
`default_nettype none

module ugev_sync
#(
  parameter logic RESET_VAL = 1'b0
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic level
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q <= RESET_VAL;
      s2_q <= RESET_VAL;
      s3_q <= RESET_VAL;
    end
    else
    begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a change is taken only once the last two stages agree
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      level <= RESET_VAL;
    else if (s2_q == s3_q)
      level <= s3_q;
  end

endmodule

`default_nettype wire

// file: src/ugev_hold_timer.sv
`timescale 1ns/1ps
`default_nettype none

module ugev_hold_timer
#(
  parameter int unsigned LIMIT = 4,
  parameter int unsigned W = 20
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cond,
  output logic reached
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // saturates so a long hold never wraps back below the limit
  always_comb
  begin
    if (!cond)
      cnt_d = '0;
    else if (cnt_q == W'(LIMIT))
      cnt_d = cnt_q;
    else
      cnt_d = cnt_q + W'(1);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end

  assign reached = cond && (cnt_q == W'(LIMIT));

endmodule

`default_nettype wire

// file: src/ugev_top.sv
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "ugev_params.svh"

// Summary of operation
// RULE1: address register clears to zero on reset
// RULE2: reserved flag and enable bits read zero
// RULE3: host activity while suspended sets wake flag
// RULE4: own upstream resume never sets wake flag
// RULE5: firmware clears wake flag after clocks restart
// RULE6: end of bus reset sets flag bit4
// RULE7: each good start-of-frame sets flag bit3
// RULE8: idle J for 3 ms sets suspend flag
// RULE9: interrupt when any enabled flag is set
// RULE10: enable bits share the flag positions
// RULE11: enables reset to 0x10
// RULE12: SE0 of 32 bit times is bus reset
// RULE13: bus reset drops function enable, address zero; the stored address bits are kept, only answer_addr goes to zero
// RULE14: flags stay until software writes zero
module ugev_top
  import ugev_pkg::*;
#(
  parameter int unsigned SUSPEND_CYCLES = `UGEV_SUSPEND_CYCLES
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic usb_dp_pin,
  input wire logic usb_dm_pin,
  input wire logic sof_ok,
  input wire logic upstream_resume,
  output logic usb_irq,
  output logic function_enable,
  output logic [6:0] answer_addr,
  output logic bus_reset,
  output logic suspended
);

  localparam int unsigned RESET_CYCLES = `UGEV_RESET_CYCLES;

  // ************************************************************
  // line sampling and condition timers
  // ************************************************************
  ugev_line_t line;
  logic line_se0;
  logic line_j;
  logic se0_long;
  logic idle_long;

  ugev_sync #(.RESET_VAL(1'b1)) u_sync_dp (
    .clk(hclk),
    .rst_n(hresetn),
    .pin(usb_dp_pin),
    .level(line.dp)
  );

  ugev_sync #(.RESET_VAL(1'b0)) u_sync_dm (
    .clk(hclk),
    .rst_n(hresetn),
    .pin(usb_dm_pin),
    .level(line.dm)
  );

  assign line_se0 = !line.dp && !line.dm;
  assign line_j = line.dp && !line.dm;

  ugev_hold_timer #(.LIMIT(RESET_CYCLES), .W(12)) u_se0_timer (
    .clk(hclk),
    .rst_n(hresetn),
    .cond(line_se0),
    .reached(se0_long)
  );

  ugev_hold_timer #(.LIMIT(SUSPEND_CYCLES), .W(20)) u_idle_timer (
    .clk(hclk),
    .rst_n(hresetn),
    .cond(line_j),
    .reached(idle_long)
  );

  // ************************************************************
  // link state
  // ************************************************************
  ugev_link_state_t state_q;
  ugev_link_state_t state_d;
  logic ev_wake;
  logic ev_eor;
  logic ev_susp;
  logic ev_reset;

  always_comb
  begin
    state_d = state_q;
    ev_wake = 1'b0;
    ev_eor = 1'b0;
    ev_susp = 1'b0;
    ev_reset = 1'b0;
    case (state_q)
      UGEV_LS_ACTIVE:
      begin
        if (se0_long)
        begin
          state_d = UGEV_LS_RESET; // RULE12
          ev_reset = 1'b1;
        end
        else if (idle_long)
        begin
          state_d = UGEV_LS_SUSPEND;
          ev_susp = 1'b1; // RULE8
        end
      end
      UGEV_LS_RESET:
      begin
        if (!line_se0)
        begin
          state_d = UGEV_LS_ACTIVE;
          ev_eor = 1'b1; // RULE6
        end
      end
      UGEV_LS_SUSPEND:
      begin
        // our own resume takes the link out without a wake event
        if (upstream_resume)
          state_d = UGEV_LS_ACTIVE; // RULE4
        else if (!line_j)
        begin
          state_d = UGEV_LS_ACTIVE;
          ev_wake = 1'b1; // RULE3
        end
      end
      default:
        state_d = UGEV_LS_ACTIVE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_q <= UGEV_LS_ACTIVE;
    else
      state_q <= state_d;
  end

  // ************************************************************
  // AHB-Lite slave
  // ************************************************************
  ugev_ahb_req_t req_q;
  logic addr_ok;
  logic take;
  logic wr_flags;
  logic wr_enables;
  logic wr_addr;
  logic [7:0] wdata;

  // only the low decode bits are compared; hsel qualifies the region
  assign addr_ok = (haddr[1:0] == 2'b00);
  assign take = hsel && htrans[1] && hready;
  assign wdata = hwdata[7:0];
  assign wr_flags = req_q.valid && req_q.write && (req_q.index == `UGEV_FLAGS_IDX);
  assign wr_enables = req_q.valid && req_q.write && (req_q.index == `UGEV_ENABLES_IDX);
  assign wr_addr = req_q.valid && req_q.write && (req_q.index == `UGEV_ADDR_IDX);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      req_q <= '0;
    else if (hready)
    begin
      req_q.valid <= take && addr_ok;
      req_q.write <= hwrite;
      req_q.index <= haddr[`UGEV_DECODE_BITS-1:2];
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  logic [7:0] flags_q;
  logic [7:0] flags_d;
  logic [7:0] enables_q;
  logic [7:0] enables_d;
  logic [7:0] fa_q;
  logic [7:0] fa_d;
  logic [7:0] set_vec;

  always_comb
  begin
    set_vec = 8'h00;
    set_vec[`UGEV_BIT_WAKE] = ev_wake;
    set_vec[`UGEV_BIT_EOR] = ev_eor;
    set_vec[`UGEV_BIT_SOF] = sof_ok; // RULE7
    set_vec[`UGEV_BIT_SUSP] = ev_susp;
  end

  // writing zero clears a flag, writing one keeps it; a set in the same cycle wins
  always_comb
  begin
    flags_d = flags_q;
    if (wr_flags)
      flags_d = flags_q & wdata; // RULE14
    flags_d = (flags_d | set_vec) & `UGEV_EVENT_MASK; // RULE2
  end

  always_comb
  begin
    enables_d = enables_q;
    if (wr_enables)
      enables_d = wdata & `UGEV_EVENT_MASK; // RULE10
  end

  // the bus reset drop of function enable overrides a write in the same cycle
  always_comb
  begin
    fa_d = fa_q;
    if (wr_addr)
      fa_d = wdata;
    if (ev_reset)
      fa_d[`UGEV_BIT_FEN] = 1'b0; // RULE13
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      flags_q <= `UGEV_FLAGS_RST;
    else
      flags_q <= flags_d;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      enables_q <= `UGEV_ENABLES_RST; // RULE11
    else
      enables_q <= enables_d;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      fa_q <= `UGEV_ADDR_RST; // RULE1
    else
      fa_q <= fa_d;
  end

  // ************************************************************
  // read data and outputs
  // ************************************************************
  logic [7:0] rd_mux;

  // read from next values so a write just before is seen
  always_comb
  begin
    rd_mux = 8'h00;
    if (take && addr_ok && !hwrite)
    begin
      case (haddr[`UGEV_DECODE_BITS-1:2])
        `UGEV_FLAGS_IDX: rd_mux = flags_d;
        `UGEV_ENABLES_IDX: rd_mux = enables_d;
        `UGEV_ADDR_IDX: rd_mux = fa_d;
        default: rd_mux = 8'h00;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      if (hready)
        hrdata <= {24'h000000, rd_mux};
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      usb_irq <= 1'b0;
    else
      usb_irq <= |(flags_d & enables_d); // RULE9
  end

  // the device answers at address zero while the function is disabled
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      function_enable <= 1'b0;
      answer_addr <= 7'h00;
      bus_reset <= 1'b0;
      suspended <= 1'b0;
    end
    else
    begin
      function_enable <= fa_d[`UGEV_BIT_FEN];
      answer_addr <= fa_d[`UGEV_BIT_FEN] ? fa_d[6:0] : 7'h00; // RULE13
      bus_reset <= (state_d == UGEV_LS_RESET);
      suspended <= (state_d == UGEV_LS_SUSPEND);
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  sequence s_host_wake;
    (state_q == UGEV_LS_SUSPEND) && !upstream_resume && !line_j;
  endsequence

  sequence s_reset_exit;
    (state_q == UGEV_LS_RESET) && !line_se0;
  endsequence

  chk_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn) // RULE2
    ((flags_q & 8'hC6) == 8'h00) && ((enables_q & 8'hC6) == 8'h00))
    else $error("reserved bit set");

  chk_host_wake_flag: assert property (@(posedge hclk) disable iff (!hresetn) // RULE3
    s_host_wake |=> flags_q[`UGEV_BIT_WAKE] && (state_q == UGEV_LS_ACTIVE))
    else $error("wake flag not set on host activity");

  chk_self_no_wake: assert property (@(posedge hclk) disable iff (!hresetn) // RULE4
    ((state_q == UGEV_LS_SUSPEND) && upstream_resume && !flags_q[`UGEV_BIT_WAKE])
    |=> !flags_q[`UGEV_BIT_WAKE])
    else $error("wake flag set by own resume");

  chk_end_reset_flag: assert property (@(posedge hclk) disable iff (!hresetn) // RULE6
    s_reset_exit |=> flags_q[`UGEV_BIT_EOR] ##1 bus_reset == 1'b0)
    else $error("end of reset not flagged");

  chk_sof_flag: assert property (@(posedge hclk) disable iff (!hresetn) // RULE7
    sof_ok |=> flags_q[`UGEV_BIT_SOF])
    else $error("sof flag not set");

  chk_suspend_flag: assert property (@(posedge hclk) disable iff (!hresetn) // RULE8
    ((state_q == UGEV_LS_ACTIVE) && idle_long && !se0_long)
    |=> flags_q[`UGEV_BIT_SUSP] && suspended)
    else $error("suspend not flagged");

  chk_irq_level: assert property (@(posedge hclk) disable iff (!hresetn) // RULE9
    usb_irq == |(flags_q & enables_q))
    else $error("interrupt level mismatch");

  chk_bus_reset_entry: assert property (@(posedge hclk) disable iff (!hresetn) // RULE12
    ((state_q == UGEV_LS_ACTIVE) && (state_d == UGEV_LS_RESET)) |-> line_se0 && $past(line_se0))
    else $error("bus reset without long se0");

  chk_reset_drops_fen: assert property (@(posedge hclk) disable iff (!hresetn) // RULE13
    ev_reset |=> !fa_q[`UGEV_BIT_FEN] && !function_enable && (answer_addr == 7'h00))
    else $error("function enable survived bus reset");

  chk_flags_sticky: assert property (@(posedge hclk) disable iff (!hresetn) // RULE14
    (flags_q[`UGEV_BIT_SOF] && !wr_flags) |=> flags_q[`UGEV_BIT_SOF])
    else $error("flag cleared without software");

  chk_enable_reset: assert property (@(posedge hclk) // RULE11
    (!$past(hresetn) && hresetn && !$past(wr_enables)) |-> (enables_q == `UGEV_ENABLES_RST))
    else $error("enable reset value wrong");

endmodule

`default_nettype wire

// file: sim/ugev_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// host on the full-speed bus: line states and frame markers
// ************************************************************
module ugev_host_model
(
  input wire logic clk,
  output logic dp,
  output logic dm,
  output logic sof_ok
);
  localparam logic [1:0] LV_J = 2'h2;
  localparam logic [1:0] LV_K = 2'h1;

  initial
  begin
    dp = 1'b1;
    dm = 1'b0;
    sof_ok = 1'b0;
  end

  // hold a line state for n cycles; se0 callers pick n against the reset length
  task automatic line(input logic [1:0] lv, input int n);
    dp <= lv[1];
    dm <= lv[0];
    repeat (n) @(posedge clk);
  endtask

  // a frame marker is real line activity, so it also breaks any idle run
  task automatic sof();
    line(LV_K, 4);
    line(LV_J, 1);
    sof_ok <= 1'b1;
    @(posedge clk);
    sof_ok <= 1'b0;
  endtask
endmodule

`default_nettype wire

// file: sim/ugev_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ugev_params.svh"

module ugev_top_tb;
  import ugev_pkg::*;
  localparam int SUSP = 600;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic upstream_resume = 1'b0;
  logic hreadyout, hresp, usb_irq, function_enable, bus_reset, suspended, dp, dm, sof_ok;
  logic [31:0] hrdata;
  logic [6:0] answer_addr;
  logic [31:0] exp_q[$];
  logic rd_pend = 1'b0;
  logic [7:0] en;
  int num_errors = 0;
  int compares = 0;

  always #4 hclk = ~hclk;

  ugev_top #(.SUSPEND_CYCLES(SUSP)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .usb_dp_pin(dp), .usb_dm_pin(dm),
    .sof_ok(sof_ok), .upstream_resume(upstream_resume), .usb_irq(usb_irq),
    .function_enable(function_enable), .answer_addr(answer_addr), .bus_reset(bus_reset),
    .suspended(suspended));

  ugev_host_model host (.clk(hclk), .dp(dp), .dm(dm), .sof_ok(sof_ok));

  // ************************************************************
  // checking and closing
  // ************************************************************
  task automatic end_of_test();
    $display("compares=%0d errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // read data is judged here, apart from the driver, in the cycle the master takes it
  always @(posedge hclk)
  begin
    if (rd_pend && hreadyout === 1'b1)
    begin
      chk_word(hrdata, (exp_q.size() > 0) ? exp_q.pop_front() : 32'hDEAD);
      chk_word({31'h0, hresp}, 32'h0);
    end
    rd_pend = hresetn && hsel && htrans[1] && !hwrite && hreadyout === 1'b1;
  end

  initial
  begin
    repeat (20000) @(posedge hclk);
    num_errors++;
    end_of_test();
  end

  // ************************************************************
  // bus master
  // ************************************************************
  task automatic wait_rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      num_errors++;
      end_of_test();
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, {24'h0, d});
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    exp_q.push_back({24'h0, exp});
    xfer(1'b0, idx, 32'h0);
  endtask

  task automatic done_test(input string name);
    repeat (3) @(posedge hclk);
    $display("test %s done", name);
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  initial
  begin
    void'($urandom(87));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`UGEV_FLAGS_IDX, 8'h00);
    rd(`UGEV_ENABLES_IDX, 8'h10);
    rd(`UGEV_ADDR_IDX, 8'h00);
    chk_word({31'h0, function_enable}, 32'h0);
    done_test("reset");
    wr(`UGEV_ENABLES_IDX, 8'hFF);
    rd(`UGEV_ENABLES_IDX, 8'h39);
    wr(`UGEV_FLAGS_IDX, 8'hFF);
    rd(`UGEV_FLAGS_IDX, 8'h00);
    wr(`UGEV_ADDR_IDX, 8'h85);
    rd(`UGEV_ADDR_IDX, 8'h85);
    rd(8'h10, 8'h00);
    chk_word({25'h0, function_enable, answer_addr}, 32'h85);
    done_test("registers");
    host.sof();
    repeat (3) @(posedge hclk);
    chk_word({31'h0, usb_irq}, 32'h1);
    rd(`UGEV_FLAGS_IDX, 8'h08);
    wr(`UGEV_FLAGS_IDX, 8'hFF);
    rd(`UGEV_FLAGS_IDX, 8'h08);
    wr(`UGEV_FLAGS_IDX, 8'hF7);
    rd(`UGEV_FLAGS_IDX, 8'h00);
    chk_word({31'h0, usb_irq}, 32'h0);
    done_test("frame start");
    // a short se0 is only a glitch, the long one is a bus reset
    host.line(2'h0, 200);
    host.line(2'h2, 10);
    rd(`UGEV_FLAGS_IDX, 8'h00);
    host.line(2'h0, 360);
    chk_word({31'h0, bus_reset}, 32'h1);
    host.line(2'h2, 10);
    rd(`UGEV_FLAGS_IDX, 8'h10);
    rd(`UGEV_ADDR_IDX, 8'h05);
    chk_word({31'h0, function_enable}, 32'h0);
    done_test("bus reset");
    for (int i = 0; i < 8; i++)
    begin
      en = 8'($urandom);
      wr(`UGEV_ENABLES_IDX, en);
      repeat (3) @(posedge hclk);
      chk_word({31'h0, usb_irq}, {31'h0, en[4]});
      rd(`UGEV_ENABLES_IDX, en & 8'h39);
    end
    done_test("masking");
    wr(`UGEV_ENABLES_IDX, 8'h39);
    wr(`UGEV_FLAGS_IDX, 8'h00);
    host.line(2'h2, SUSP + 20);
    chk_word({31'h0, suspended}, 32'h1);
    rd(`UGEV_FLAGS_IDX, 8'h01);
    upstream_resume <= 1'b1;
    host.line(2'h1, 20);
    upstream_resume <= 1'b0;
    host.line(2'h2, 5);
    rd(`UGEV_FLAGS_IDX, 8'h01);
    chk_word({31'h0, suspended}, 32'h0);
    host.line(2'h2, SUSP + 20);
    host.line(2'h1, 20);
    host.line(2'h2, 5);
    rd(`UGEV_FLAGS_IDX, 8'h21);
    wr(`UGEV_FLAGS_IDX, 8'h00);
    rd(`UGEV_FLAGS_IDX, 8'h00);
    done_test("suspend and wake");
    end_of_test();
  end
endmodule

`default_nettype wire
